// File: rtl/asirx_top.v
/*
 Receive configuration and slot capture of the primary serial port:
 three configuration registers, bit clock edge selection, frame tracking,
 per-channel input pin steering and channel 1 word capture into a FIFO.
 Assumes a byte register port driven by the control interface logic on
 CLK, link pins asynchronous to CLK, and an internal clock generator on
 CLK for controller mode.
*/
// Overview of operation
// (RULE1) Edge bit picks default or opposite edge
// (RULE2) Controller mode may latch with internal frame sync
// (RULE3) Controller mode may latch with internal bit clock
// (RULE4) Offset delays slot 0 MSB position
// (RULE5) Offset hits TDM slot0, both half-frame slot0s
// (RULE6) Per-channel bit picks primary or secondary input
// (RULE7) Timing and pin registers reset to zero
// (RULE8) Channel 1 resets enabled, slot 0, reserved zero
// (RULE9) Channel 1 disabled ignores input, else feeds DAC
// (RULE10) Slot 0-15 left/TDM, 16-31 right/TDM
// (RULE11) Host sends MSB first, stable at sampling edge
`timescale 1ns/1ps
`default_nettype none
`include "asirx_defs.vh"

module asirx_top (
    input  wire        CLK,
    input  wire        NRST,
    input  wire [7:0]  REG_ADDR,
    input  wire [7:0]  REG_WDATA,
    input  wire        REG_WE,
    output reg  [7:0]  REG_RDATA,
    input  wire        CONTROLLER_MODE,
    input  wire        BIT_CLOCK_POLARITY,
    input  wire [1:0]  FRAME_FORMAT,
    input  wire        INT_BCLK,
    input  wire        INT_FSYNC,
    input  wire        EXT_BCLK,
    input  wire        EXT_FSYNC,
    input  wire        PRIMARY_DATA_INPUT,
    input  wire        SECONDARY_DATA_INPUT,
    output reg  [7:0]  CHAN_SERIAL_BIT,
    output reg         CHAN_BIT_STROBE,
    output wire [31:0] DAC_DATA,
    output wire        DAC_VALID,
    input  wire        DAC_READY,
    output reg         RX_OVERRUN
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg  [7:0]               rx_timing_config;
    reg  [7:0]               rx_input_pin_select;
    reg  [7:0]               rx_channel1_config;
    wire [3:0]               pins_sync;
    wire                     ext_bclk_s;
    wire                     ext_fsync_s;
    wire                     din_s;
    wire                     secondary_data_input_s;
    wire                     bclk_now;
    wire                     fsync_now;
    reg                      bclk_prev;
    reg                      fsync_prev;
    wire                     bclk_rise;
    wire                     bclk_fall;
    wire                     sample_evt;
    wire                     is_tdm;
    wire                     is_i2s;
    wire                     left_start;
    wire                     right_start;
    reg  [`ASIRX_POS_W-1:0]  pos;
    reg                      half_right;
    reg  [`ASIRX_POS_W-1:0]  cur_pos;
    reg                      cur_half;
    wire [`ASIRX_POS_W-1:0]  lead;
    wire [`ASIRX_POS_W-1:0]  rel;
    wire                     rel_ok;
    wire [4:0]               cur_slot;
    wire                     ch1_enable;
    wire [4:0]               ch1_slot;
    wire                     ch1_bit;
    wire                     ch1_hit;
    reg  [31:0]              shift;
    reg  [31:0]              pend_data;
    reg                      pend_valid;
    wire                     fifo_ready;
    wire                     word_done;
    wire                     ch1_wr;
    integer                  n;

    // Steers one channel to the primary or secondary data pin
    function pick_pin;
        input sel;
        input prim;
        input sec;
        begin
            pick_pin = sel ? sec : prim;
        end
    endfunction

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    assign ch1_wr = REG_WE && (REG_ADDR == `ASIRX_ADDR_CH1);

    // Writes land the cycle after the strobe; reserved bits stay zero
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            rx_timing_config    <= `ASIRX_RST_TIMING; // RULE7
            rx_input_pin_select <= `ASIRX_RST_PINSEL; // RULE7
            rx_channel1_config  <= `ASIRX_RST_CH1;    // RULE8
        end
        else if (REG_WE)
        begin
            if (REG_ADDR == `ASIRX_ADDR_TIMING)
                rx_timing_config <= REG_WDATA;
            else if (REG_ADDR == `ASIRX_ADDR_PINSEL)
                rx_input_pin_select <= REG_WDATA;
            else if (ch1_wr)
                rx_channel1_config <= REG_WDATA & `ASIRX_CH1_WMASK; // RULE8
        end
    end

    // Registered read data, unmapped offsets answer zero
    always @(posedge CLK)
    begin
        if (!NRST)
            REG_RDATA <= `ASIRX_RD_UNMAPPED;
        else if (REG_ADDR == `ASIRX_ADDR_TIMING)
            REG_RDATA <= rx_timing_config;
        else if (REG_ADDR == `ASIRX_ADDR_PINSEL)
            REG_RDATA <= rx_input_pin_select;
        else if (REG_ADDR == `ASIRX_ADDR_CH1)
            REG_RDATA <= rx_channel1_config;
        else
            REG_RDATA <= `ASIRX_RD_UNMAPPED;
    end

    assign ch1_enable = rx_channel1_config[`ASIRX_CH1_EN_BIT];
    assign ch1_slot   = rx_channel1_config[`ASIRX_SLOT_MSB:`ASIRX_SLOT_LSB];

    // ------------------------------------------------------------------
    // Link pin synchronisers and clock source selection
    // ------------------------------------------------------------------
    asirx_sync #(
        .WIDTH (4)
    ) u_sync (
        .CLK  (CLK),
        .NRST (NRST),
        .D    ({SECONDARY_DATA_INPUT, PRIMARY_DATA_INPUT, EXT_FSYNC, EXT_BCLK}),
        .Q    (pins_sync)
    );

    assign ext_bclk_s  = pins_sync[0];
    assign ext_fsync_s = pins_sync[1];
    assign din_s       = pins_sync[2];
    assign secondary_data_input_s      = pins_sync[3];

    // Internal sources are only honoured while the device is controller
    assign bclk_now  = (CONTROLLER_MODE && rx_timing_config[`ASIRX_INT_BCLK_BIT])
                       ? INT_BCLK : ext_bclk_s; // RULE3
    assign fsync_now = (CONTROLLER_MODE && rx_timing_config[`ASIRX_INT_FS_BIT])
                       ? INT_FSYNC : ext_fsync_s; // RULE2

    always @(posedge CLK)
    begin
        if (!NRST)
            bclk_prev <= 1'b0;
        else
            bclk_prev <= bclk_now;
    end

    assign bclk_rise = bclk_now & ~bclk_prev;
    assign bclk_fall = ~bclk_now & bclk_prev;
    // Polarity picks the default edge, the edge bit flips to the other
    assign sample_evt = (BIT_CLOCK_POLARITY ^ rx_timing_config[`ASIRX_EDGE_BIT])
                        ? bclk_fall : bclk_rise; // RULE1

    // ------------------------------------------------------------------
    // Frame tracking at the sampling edge
    // ------------------------------------------------------------------
    assign is_tdm = (FRAME_FORMAT == `ASIRX_FMT_TDM);
    assign is_i2s = (FRAME_FORMAT == `ASIRX_FMT_I2S);

    // I2S starts its left half on the falling frame sync edge
    assign left_start  = is_i2s ? (fsync_prev & ~fsync_now) : (~fsync_prev & fsync_now);
    assign right_start = !is_tdm && (is_i2s ? (~fsync_prev & fsync_now)
                                            : (fsync_prev & ~fsync_now));

    // Bit position of the edge now being sampled
    always @*
    begin
        cur_pos  = pos;
        cur_half = half_right;
        if (left_start)
        begin
            cur_pos  = {`ASIRX_POS_W{1'b0}};
            cur_half = 1'b0;
        end
        else if (right_start)
        begin
            cur_pos  = {`ASIRX_POS_W{1'b0}};
            cur_half = 1'b1;
        end
        else if (pos != `ASIRX_POS_MAX)
            cur_pos = pos + 1'b1;
    end

    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            fsync_prev <= 1'b0;
            pos        <= `ASIRX_POS_MAX;
            half_right <= 1'b0;
        end
        else if (sample_evt)
        begin
            fsync_prev <= fsync_now;
            pos        <= cur_pos;
            half_right <= cur_half;
        end
    end

    // I2S carries a one-bit delay; the offset adds to it in either half
    assign lead   = {{(`ASIRX_POS_W-5){1'b0}},
                     rx_timing_config[`ASIRX_OFFSET_MSB:`ASIRX_OFFSET_LSB]}
                    + {{(`ASIRX_POS_W-1){1'b0}}, is_i2s}; // RULE4 RULE5
    assign rel    = cur_pos - lead; // RULE4
    assign rel_ok = (cur_pos >= lead) && (cur_pos != `ASIRX_POS_MAX)
                    && (rel < (is_tdm ? `ASIRX_TDM_LIMIT : `ASIRX_HALF_LIMIT)); // RULE5
    // Half-frame slots land at 0-15 left, 16-31 right
    assign cur_slot = is_tdm ? rel[9:5] : {cur_half, rel[8:5]}; // RULE10

    // ------------------------------------------------------------------
    // Per-channel pin steering
    // ------------------------------------------------------------------
    // One bit per channel per sampling edge, for the downstream slot logic
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            CHAN_SERIAL_BIT <= 8'h00;
            CHAN_BIT_STROBE <= 1'b0;
        end
        else
        begin
            CHAN_BIT_STROBE <= sample_evt;
            if (sample_evt)
                for (n = 0; n < 8; n = n + 1)
                    CHAN_SERIAL_BIT[n] <= pick_pin(rx_input_pin_select[n],
                                                   din_s, secondary_data_input_s); // RULE6
        end
    end

    assign ch1_bit = pick_pin(rx_input_pin_select[0], din_s, secondary_data_input_s); // RULE6

    // ------------------------------------------------------------------
    // Channel 1 capture
    // ------------------------------------------------------------------
    // Disabled channel leaves the shifter and FIFO untouched
    assign ch1_hit   = sample_evt && ch1_enable && rel_ok && (cur_slot == ch1_slot); // RULE9
    assign word_done = ch1_hit && (rel[4:0] == `ASIRX_LAST_BIT);

    // MSB arrives first, so shift left
    always @(posedge CLK)
    begin
        if (!NRST)
            shift <= 32'h00000000;
        else if (ch1_hit)
            shift <= {shift[30:0], ch1_bit}; // RULE11
    end

    // One-word holding stage absorbs FIFO stalls; the link cannot stall,
    // so a second word arriving while one still waits is lost and flagged
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            pend_data  <= 32'h00000000;
            pend_valid <= 1'b0;
            RX_OVERRUN <= 1'b0;
        end
        else
        begin
            if (word_done && (!pend_valid || fifo_ready))
            begin
                pend_data  <= {shift[30:0], ch1_bit}; // RULE9
                pend_valid <= 1'b1;
            end
            else if (fifo_ready)
                pend_valid <= 1'b0;
            // Set wins over the clear from a channel 1 register write
            if (word_done && pend_valid && !fifo_ready)
                RX_OVERRUN <= 1'b1;
            else if (ch1_wr)
                RX_OVERRUN <= 1'b0;
        end
    end

    asirx_fifo #(
        .WIDTH (`ASIRX_WORD_BITS),
        .DEPTH (`ASIRX_FIFO_DEPTH),
        .AW    (`ASIRX_FIFO_AW)
    ) u_fifo (
        .CLK       (CLK),
        .NRST      (NRST),
        .IN_VALID  (pend_valid),
        .IN_READY  (fifo_ready),
        .IN_DATA   (pend_data),
        .OUT_VALID (DAC_VALID),
        .OUT_READY (DAC_READY),
        .OUT_DATA  (DAC_DATA)
    );

endmodule // asirx_top

`default_nettype wire

// File: rtl/asirx_defs.vh
/*
 Constants for the receive side of the primary serial port: register
 offsets, reset values, field positions, framing codes and slot layout.
 Assumes it is included by bare name from the files under rtl/.
*/
`ifndef ASIRX_DEFS_VH
`define ASIRX_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------
`define ASIRX_ADDR_TIMING   8'h26
`define ASIRX_ADDR_PINSEL   8'h27
`define ASIRX_ADDR_CH1      8'h28
`define ASIRX_RST_TIMING    8'h00
`define ASIRX_RST_PINSEL    8'h00
`define ASIRX_RST_CH1       8'h20
`define ASIRX_RD_UNMAPPED   8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ASIRX_EDGE_BIT      7
`define ASIRX_INT_FS_BIT    6
`define ASIRX_INT_BCLK_BIT  5
`define ASIRX_OFFSET_MSB    4
`define ASIRX_OFFSET_LSB    0
`define ASIRX_CH1_EN_BIT    5
`define ASIRX_SLOT_MSB      4
`define ASIRX_SLOT_LSB      0
`define ASIRX_CH1_WMASK     8'h3F

// ----------------------------------------------------------------------
// Framing and slot layout
// ----------------------------------------------------------------------
`define ASIRX_FMT_TDM       2'h0
`define ASIRX_FMT_I2S       2'h1
`define ASIRX_FMT_LJ        2'h2
`define ASIRX_WORD_BITS     32
`define ASIRX_POS_W         11
`define ASIRX_POS_MAX       11'h7FF
`define ASIRX_TDM_LIMIT     11'h400
`define ASIRX_HALF_LIMIT    11'h200
`define ASIRX_LAST_BIT      5'h1F
`define ASIRX_FIFO_DEPTH    32
`define ASIRX_FIFO_AW       5

`endif

// File: rtl/asirx_sync.v
/*
 Three-stage input synchroniser for a group of pins. The held output
 changes only when the second and third stages agree.
 Assumes inputs arrive from outside the CLK domain.
*/
`timescale 1ns/1ps
`default_nettype none

module asirx_sync #(
    parameter WIDTH = 4
) (
    input  wire             CLK,
    input  wire             NRST,
    input  wire [WIDTH-1:0] D,
    output reg  [WIDTH-1:0] Q
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    integer         i;

    // ------------------------------------------------------------------
    // Stages and agreement filter
    // ------------------------------------------------------------------
    // Stage 1 is read by stage 2 only, to keep metastability contained
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
            stage3 <= {WIDTH{1'b0}};
            Q      <= {WIDTH{1'b0}};
        end
        else
        begin
            stage1 <= D;
            stage2 <= stage1;
            stage3 <= stage2;
            for (i = 0; i < WIDTH; i = i + 1)
                if (stage2[i] == stage3[i])
                    Q[i] <= stage3[i];
        end
    end

endmodule // asirx_sync

`default_nettype wire

// File: rtl/asirx_fifo.v
/*
 Word FIFO between the serial capture and the DAC path, flip-flop
 storage addressed by index, valid/ready on both sides.
 Assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module asirx_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             CLK,
    input  wire             NRST,
    input  wire             IN_VALID,
    output wire             IN_READY,
    input  wire [WIDTH-1:0] IN_DATA,
    output wire             OUT_VALID,
    input  wire             OUT_READY,
    output reg  [WIDTH-1:0] OUT_DATA
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_idx;
    reg [AW-1:0]    rd_idx;
    reg [AW:0]      count;
    wire            do_wr;
    wire            do_rd;
    wire [AW-1:0]   next_rd;

    // Honest flags straight from the fill count
    assign IN_READY  = (count != DEPTH[AW:0]);
    assign OUT_VALID = (count != {(AW+1){1'b0}});
    assign do_wr     = IN_VALID & IN_READY;
    assign do_rd     = OUT_VALID & OUT_READY;
    assign next_rd   = !do_rd ? rd_idx
                     : (rd_idx == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_idx + 1'b1;

    // ------------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------------
    always @(posedge CLK)
    begin
        if (do_wr)
            mem[wr_idx] <= IN_DATA;
    end

    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            wr_idx <= {AW{1'b0}};
            rd_idx <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
                wr_idx <= (wr_idx == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_idx + 1'b1;
            rd_idx <= next_rd;
            if (do_wr && !do_rd)
                count <= count + 1'b1;
            else if (do_rd && !do_wr)
                count <= count - 1'b1;
        end
    end

    // Head word in a flip-flop; a write into the head slot bypasses mem
    always @(posedge CLK)
    begin
        if (!NRST)
            OUT_DATA <= {WIDTH{1'b0}};
        else if (do_wr && wr_idx == next_rd)
            OUT_DATA <= IN_DATA;
        else
            OUT_DATA <= mem[next_rd];
    end

endmodule // asirx_fifo

`default_nettype wire

// File: dv/asirx_assertions.sv
/*
 Checker for the receive configuration block: register read-back, reset
 values, pin steering, DAC hold and overrun behaviour.
 Assumes one CLK domain, synchronous active-low NRST, bound to asirx_top.
*/
`timescale 1ns/1ps
`default_nettype none

module asirx_assertions (
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic        REG_WE,
    input wire logic [7:0]  REG_RDATA,
    input wire logic [7:0]  CHAN_SERIAL_BIT,
    input wire logic        CHAN_BIT_STROBE,
    input wire logic [31:0] DAC_DATA,
    input wire logic        DAC_VALID,
    input wire logic        DAC_READY,
    input wire logic        RX_OVERRUN
);
    logic [7:0] sel_q;

    // --------------------------------------------------------------
    // Helper logic
    // --------------------------------------------------------------
    // Pin select shadow, written on every register write to offset 8'h27
    always_ff @(posedge CLK)
    begin
        if (!NRST)
            sel_q <= 8'h00;
        else if (REG_WE && REG_ADDR == 8'h27)
            sel_q <= REG_WDATA;
    end

    default clocking dc @(posedge CLK); endclocking
    default disable iff (!NRST);

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    AST_RESET_VALUES: assert property (!$past(NRST) && !REG_WE
        && REG_ADDR inside {8'h26, 8'h27, 8'h28}
        |=> REG_RDATA == (($past(REG_ADDR) == 8'h28) ? 8'h20 : 8'h00))
        else $error("register not at its reset value");
    AST_TIMING_READBACK: assert property (REG_WE && REG_ADDR == 8'h26
        ##1 !REG_WE && REG_ADDR == 8'h26 |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("timing register read-back differs");
    AST_PINSEL_READBACK: assert property (REG_WE && REG_ADDR == 8'h27
        ##1 !REG_WE && REG_ADDR == 8'h27 |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("pin select read-back differs");
    AST_CH1_READBACK: assert property (REG_WE && REG_ADDR == 8'h28
        ##1 !REG_WE && REG_ADDR == 8'h28 |=> REG_RDATA == ($past(REG_WDATA, 2) & 8'h3F))
        else $error("channel 1 read-back differs");
    AST_CH1_RESERVED: assert property (REG_ADDR == 8'h28 |=> REG_RDATA[7:6] == 2'b00)
        else $error("reserved channel 1 bits not zero");
    AST_STROBE_SPACING: assert property (CHAN_BIT_STROBE |=> !CHAN_BIT_STROBE [*6])
        else $error("more than one sampling event per bit period");
    AST_PIN_STEERING: assert property (CHAN_BIT_STROBE
        |-> ((CHAN_SERIAL_BIT & ~sel_q) == 8'h00 || (CHAN_SERIAL_BIT & ~sel_q) == ~sel_q)
        && ((CHAN_SERIAL_BIT & sel_q) == 8'h00 || (CHAN_SERIAL_BIT & sel_q) == sel_q))
        else $error("channel bits not steered by pin select");
    AST_DAC_HOLD: assert property (DAC_VALID && !DAC_READY
        |=> DAC_VALID && $stable(DAC_DATA))
        else $error("DAC word changed while not taken");
    AST_OVERRUN_STICKY: assert property (RX_OVERRUN
        && !(REG_WE && REG_ADDR == 8'h28) |=> RX_OVERRUN)
        else $error("overrun flag dropped without a clear");

    // Main scenarios seen
    COV_WORD_TAKEN: cover property (DAC_VALID && DAC_READY);
    COV_OVERRUN: cover property ($rose(RX_OVERRUN));
    COV_SECONDARY: cover property (CHAN_BIT_STROBE && sel_q != 8'h00);
endmodule // asirx_assertions

bind asirx_top asirx_assertions u_chk (
    .CLK             (CLK),
    .NRST            (NRST),
    .REG_ADDR        (REG_ADDR),
    .REG_WDATA       (REG_WDATA),
    .REG_WE          (REG_WE),
    .REG_RDATA       (REG_RDATA),
    .CHAN_SERIAL_BIT (CHAN_SERIAL_BIT),
    .CHAN_BIT_STROBE (CHAN_BIT_STROBE),
    .DAC_DATA        (DAC_DATA),
    .DAC_VALID       (DAC_VALID),
    .DAC_READY       (DAC_READY),
    .RX_OVERRUN      (RX_OVERRUN)
);

`default_nettype wire

// File: dv/asirx_host_model.sv
/*
 Host side of the link: sends TDM frames, two data lines, MSB first.
 Assumes the caller starts a frame off the CLK edges; the bit clock
 stands low between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module asirx_host_model (
    output logic BCLK,
    output logic FSYNC,
    output logic DATA_PRI,
    output logic DATA_SEC
);
    // Idle link at time zero
    initial
    begin
        BCLK = 1'b0;
        FSYNC = 1'b0;
        DATA_PRI = 1'b0;
        DATA_SEC = 1'b0;
    end

    // --------------------------------------------------------------
    // Frame sender
    // --------------------------------------------------------------
    // Data changes mid non-sampling phase, so each bit is settled at the chosen edge
    task automatic send_frame(input logic [63:0] pri, input logic [63:0] sec,
                              input int nbits, input logic [4:0] off, input logic inv);
        int i;
        int rel;
        for (i = 0; i < nbits; i++)
        begin
            BCLK = inv;
            #20;
            rel = i - int'(off);
            FSYNC = (i == 0);
            DATA_PRI = (rel >= 0 && rel < 64) ? pri[63 - rel] : 1'b0;
            DATA_SEC = (rel >= 0 && rel < 64) ? sec[63 - rel] : 1'b0;
            #20;
            BCLK = ~inv;
            #40;
        end
        // Released data lines show the inverse, never a stale value; BCLK and FSYNC go low
        BCLK = 1'b0;
        FSYNC = 1'b0;
        DATA_PRI = ~DATA_PRI;
        DATA_SEC = ~DATA_SEC;
    endtask
endmodule // asirx_host_model

`default_nettype wire

// File: dv/test_asi_receive_config.sv
/*
 Testbench: register port tasks and TDM frame scenarios for asirx_top.
 Assumes the host model in asirx_host_model.sv and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none

module test_asi_receive_config;
    localparam logic [31:0] WA = 32'hC35A0F81;
    localparam logic [31:0] WB = 32'h1E6DB427;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  reg_addr = 8'h26;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_we = 1'b0;
    logic        ctrl_mode = 1'b0;
    logic        use_int = 1'b0;
    logic        dac_ready = 1'b0;
    logic [7:0]  reg_rdata;
    logic [7:0]  chan_bits;
    logic        chan_strobe;
    logic [31:0] dac_data;
    logic        dac_valid;
    logic        rx_overrun;
    logic        h_bclk;
    logic        h_fsync;
    logic        h_pri;
    logic        h_sec;
    logic [7:0]  int_pipe;
    int          checked = 0;
    int          num_errors = 0;
    int          cycles = 0;

    // Stand-in internal generator: host clocks retimed on CLK like the pins
    always @(posedge clk)
        int_pipe <= {int_pipe[5:0], h_fsync, h_bclk};

    asirx_top uut (
        .CLK(clk), .NRST(nrst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WE(reg_we), .REG_RDATA(reg_rdata), .CONTROLLER_MODE(ctrl_mode),
        .BIT_CLOCK_POLARITY(1'b0), .FRAME_FORMAT(2'h0),
        .INT_BCLK(use_int & int_pipe[6]), .INT_FSYNC(use_int & int_pipe[7]),
        .EXT_BCLK(use_int ? 1'b0 : h_bclk), .EXT_FSYNC(use_int ? 1'b0 : h_fsync),
        .PRIMARY_DATA_INPUT(h_pri), .SECONDARY_DATA_INPUT(h_sec),
        .CHAN_SERIAL_BIT(chan_bits), .CHAN_BIT_STROBE(chan_strobe), .DAC_DATA(dac_data),
        .DAC_VALID(dac_valid), .DAC_READY(dac_ready), .RX_OVERRUN(rx_overrun)
    );
    asirx_host_model host (.BCLK(h_bclk), .FSYNC(h_fsync), .DATA_PRI(h_pri), .DATA_SEC(h_sec));

    always #5 clk = ~clk;

    // Hang guard: the scenarios need about 12000 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            num_errors++;
            close_out();
        end
    end

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic close_out;
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask

    // Read data answers one cycle after the address is taken
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1;
        cmp_val("reg_rdata", {24'h0, exp}, {24'h0, reg_rdata});
    endtask

    task automatic frame(input logic [63:0] p, input logic [63:0] s, input int nb,
                         input logic [4:0] off, input logic inv);
        @(posedge clk);
        #3;
        host.send_frame(p, s, nb, off, inv);
    endtask

    task automatic take_word(input logic [31:0] exp);
        int n;
        n = 0;
        #1;
        while (dac_valid !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp_val("dac_valid", 32'h1, {31'h0, dac_valid});
        cmp_val("dac_data", exp, dac_data);
        @(posedge clk);
        dac_ready <= 1'b1;
        @(posedge clk);
        dac_ready <= 1'b0;
    endtask

    task automatic no_word;
        repeat (50) @(posedge clk);
        #1;
        cmp_val("dac_valid", 32'h0, {31'h0, dac_valid});
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        logic [31:0] k;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd(8'h26, 8'h00);
        rd(8'h27, 8'h00);
        rd(8'h28, 8'h20);
        rd(8'h40, 8'h00);
        wr(8'h28, 8'hFF);
        rd(8'h28, 8'h3F);
        wr(8'h26, 8'h9F);
        rd(8'h26, 8'h9F);
        wr(8'h26, 8'h00);
        wr(8'h28, 8'h20);
        frame({WA, WB}, {~WA, ~WB}, 32, 5'd0, 1'b0);
        take_word(WA);
        wr(8'h27, 8'h01);
        frame({WA, WB}, {~WA, ~WB}, 32, 5'd0, 1'b0);
        take_word(~WA);
        wr(8'h27, 8'hFE);
        frame({WA, WB}, {~WA, ~WB}, 32, 5'd0, 1'b0);
        take_word(WA);
        wr(8'h27, 8'h00);
        wr(8'h28, 8'h21);
        frame({WA, WB}, {~WA, ~WB}, 64, 5'd0, 1'b0);
        take_word(WB);
        wr(8'h28, 8'h20);
        wr(8'h26, 8'h1F);
        frame({WA, WB}, {~WA, ~WB}, 63, 5'd31, 1'b0);
        take_word(WA);
        wr(8'h26, 8'h80);
        frame({WA, WB}, {~WA, ~WB}, 32, 5'd0, 1'b1);
        take_word(WA);
        wr(8'h26, 8'h60);
        ctrl_mode <= 1'b1;
        use_int <= 1'b1;
        frame({WB, WA}, {~WB, ~WA}, 32, 5'd0, 1'b0);
        take_word(WB);
        wr(8'h26, 8'h00);
        frame({WB, WA}, {~WB, ~WA}, 32, 5'd0, 1'b0);
        no_word();
        ctrl_mode <= 1'b0;
        use_int <= 1'b0;
        wr(8'h28, 8'h00);
        frame({WA, WB}, {~WA, ~WB}, 32, 5'd0, 1'b0);
        no_word();
        wr(8'h28, 8'h20);
        // 34 words into 32 FIFO slots plus the holding stage, DAC stalled
        for (k = 0; k < 34; k++)
            frame({32'h5A000000 + k, 32'h0}, 64'h0, 32, 5'd0, 1'b0);
        repeat (20) @(posedge clk);
        #1;
        cmp_val("rx_overrun", 32'h1, {31'h0, rx_overrun});
        for (k = 0; k < 33; k++)
            take_word(32'h5A000000 + k);
        no_word();
        wr(8'h28, 8'h20);
        #1;
        cmp_val("rx_overrun", 32'h0, {31'h0, rx_overrun});
        close_out();
    end
endmodule // test_asi_receive_config

`default_nettype wire
